/* File: rtl/pex_pkg.sv */
// shared constants and types of the open-drain port expander
package pex_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int N_PORTS = 8;
  localparam int PORT_MAX_NS = 4000;
  localparam int PORT_MAX_CYC = (PORT_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SCL_MAX_HZ = 400_000;
  localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
  localparam int RESP_LAT_CYC = 4;
  localparam int MIN_HALF_CYC = 4;
  localparam logic [6:0] ADDR_BASE = 7'h60;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [2:0] INIT_WAIT = 3'h3;
  localparam logic RW_READ = 1'b1;
  localparam int BUS_SCL = 0;
  localparam int BUS_SDA = 1;
  localparam int BUS_CLR = 2;
  localparam logic [2:0] BUS_IDLE_LVL = 3'h7;
  typedef enum logic [2:0] {
    PEX_IDLE = 3'h0,
    PEX_ADDR = 3'h1,
    PEX_AACK = 3'h3,
    PEX_WDATA = 3'h2,
    PEX_WACK = 3'h6,
    PEX_RDATA = 3'h7,
    PEX_RACK = 3'h5
  } pex_state_type;
endpackage

/* File: rtl/pex_sync.sv */
// two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module pex_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic [W-1:0] i_async, // raw levels
  output logic [W-1:0] o_sync // levels after two flops
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } pex_sync_regs_type;

  pex_sync_regs_type r_r;
  pex_sync_regs_type r_nxt;

  // refused at elaboration: a zero-width synchroniser has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("pex_sync: width must be at least one");
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = i_async;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r_r <= {RST_VAL, RST_VAL};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_sync = r_r.s2;
endmodule

/* File: rtl/pex_top.sv */
// eight-port open-drain expander on a two-wire target bus with latched change alert
`timescale 1ns/1ps
module pex_top #(
  parameter int N_PORTS = pex_pkg::N_PORTS
) (
  input wire logic i_ref_clk, // 50 MHz system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_scl, // bus clock pin level
  input wire logic i_sda_i, // bus data pin level
  output logic o_sda_o, // bus data drive value, always low
  output logic o_sda_oe, // bus data pulled low when high
  input wire logic i_clr_n, // interface clear, active low
  input wire logic [1:0] i_addr_select_a, // level code of first address pin
  input wire logic [1:0] i_addr_select_b, // level code of second address pin
  input wire logic [N_PORTS-1:0] i_expander_pins_i, // port pin levels
  output logic [N_PORTS-1:0] o_expander_pins_o, // port drive value, always low
  output logic [N_PORTS-1:0] o_expander_pins_oe, // port pulled low when high
  output logic [1:0] o_pullup_en, // pullup enable per group of four ports
  output logic o_alert_n_o, // alert drive value, always low
  output logic o_alert_n_oe // alert pulled low when high
);
  typedef struct packed {
    pex_pkg::pex_state_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic sda_oe;
    logic acc;
    logic scl_p;
    logic sda_p;
    logic [N_PORTS-1:0] outl;
    logic [N_PORTS-1:0] snap;
    logic [N_PORTS-1:0] pins_p;
    logic alert;
    logic [6:0] dev_addr;
    logic [1:0] pu_en;
    logic [2:0] init_cnt;
    logic init_done;
  } pex_regs_type;

  pex_regs_type r_r;
  pex_regs_type r_nxt;
  logic [2:0] bus_s;
  logic [N_PORTS+3:0] port_s;
  logic [N_PORTS-1:0] pins_s;
  logic [1:0] sel_a_s;
  logic [1:0] sel_b_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_hit;
  logic clr_ev;
  logic [N_PORTS-1:0] diff_m;
  logic [N_PORTS-1:0] edge_m;

  // settings that the byte-wide transfer, the port timing or the bus sampling cannot serve are refused at elaboration
  if (N_PORTS != 8) begin : g_bad_ports
    $error("pex_top: the byte transfer serves exactly eight ports");
  end
  if (pex_pkg::RESP_LAT_CYC > pex_pkg::PORT_MAX_CYC) begin : g_bad_port_time
    $error("pex_top: clock too slow for port timing");
  end
  if (pex_pkg::SCL_HALF_CYC < pex_pkg::MIN_HALF_CYC) begin : g_bad_bus_time
    $error("pex_top: clock too slow to sample the bus");
  end

  // bus pins are sampled at 50 MHz, far above the 400 kHz bus, so edges are seen reliably
  pex_sync #(.W(3), .RST_VAL(pex_pkg::BUS_IDLE_LVL)) u_bus_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_clr_n, i_sda_i, i_scl}),
    .o_sync(bus_s)
  );

  pex_sync #(.W(N_PORTS + 4), .RST_VAL('0)) u_port_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_addr_select_b, i_addr_select_a, i_expander_pins_i}),
    .o_sync(port_s)
  );

  assign pins_s = port_s[N_PORTS-1:0];
  assign sel_a_s = port_s[N_PORTS+1:N_PORTS];
  assign sel_b_s = port_s[N_PORTS+3:N_PORTS+2];

  assign scl_rise = r_r.init_done & bus_s[pex_pkg::BUS_SCL] & ~r_r.scl_p;
  assign scl_fall = r_r.init_done & ~bus_s[pex_pkg::BUS_SCL] & r_r.scl_p;
  assign start_ev = r_r.init_done & bus_s[pex_pkg::BUS_SCL] & r_r.scl_p & r_r.sda_p & ~bus_s[pex_pkg::BUS_SDA];
  assign stop_ev = r_r.init_done & bus_s[pex_pkg::BUS_SCL] & r_r.scl_p & ~r_r.sda_p & bus_s[pex_pkg::BUS_SDA];
  assign addr_hit = (r_r.st == pex_pkg::PEX_ADDR) && scl_fall && (r_r.cnt == pex_pkg::BIT_LAST)
    && (r_r.sh[7:1] == r_r.dev_addr);
  // the clear comes at our address acknowledge or at the STOP of our access
  assign clr_ev = bus_s[pex_pkg::BUS_CLR] & (addr_hit | (stop_ev & r_r.acc));
  // released ports are the inputs; driven-low ports are not watched
  assign diff_m = r_r.init_done ? ((pins_s ^ r_r.snap) & r_r.outl) : '0;
  assign edge_m = r_r.init_done ? ((pins_s ^ r_r.pins_p) & r_r.outl) : '0;

  always_comb begin
    r_nxt = r_r;
    r_nxt.scl_p = bus_s[pex_pkg::BUS_SCL];
    r_nxt.sda_p = bus_s[pex_pkg::BUS_SDA];
    r_nxt.pins_p = pins_s;
    if (!r_r.init_done) begin
      r_nxt.init_cnt = r_r.init_cnt + 3'h1;
      if (r_r.init_cnt == pex_pkg::INIT_WAIT) begin
        // address straps are caught once, after the synchronisers have filled
        r_nxt.dev_addr = pex_pkg::ADDR_BASE | {3'h0, sel_b_s, sel_a_s};
        // the address picks power-up levels and pullups, one choice per nibble
        r_nxt.outl = {{4{sel_b_s[0]}}, {4{sel_a_s[0]}}};
        r_nxt.pu_en = {sel_b_s[1], sel_a_s[1]};
        r_nxt.snap = pins_s;
        r_nxt.init_done = 1'b1;
      end
    end
    // a fresh edge in the clear cycle wins, otherwise the flag holds until cleared
    if (clr_ev) begin
      r_nxt.alert = |edge_m;
      r_nxt.snap = pins_s;
    end else begin
      r_nxt.alert = r_r.alert | (|diff_m);
    end
    if (start_ev) begin
      r_nxt.st = pex_pkg::PEX_ADDR;
      r_nxt.cnt = 4'h0;
      r_nxt.acc = 1'b0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop_ev) begin
      r_nxt.st = pex_pkg::PEX_IDLE;
      r_nxt.acc = 1'b0;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r_r.st)
        pex_pkg::PEX_IDLE: begin
          r_nxt.sda_oe = 1'b0;
        end
        pex_pkg::PEX_ADDR, pex_pkg::PEX_WDATA: begin
          if (scl_rise) begin
            r_nxt.sh = {r_r.sh[6:0], bus_s[pex_pkg::BUS_SDA]};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall && r_r.cnt == pex_pkg::BIT_LAST) begin
            if (r_r.st == pex_pkg::PEX_WDATA) begin
              r_nxt.outl = r_r.sh;
              r_nxt.sda_oe = 1'b1;
              r_nxt.st = pex_pkg::PEX_WACK;
            end else if (addr_hit) begin
              r_nxt.rw = r_r.sh[0];
              r_nxt.acc = 1'b1;
              r_nxt.sda_oe = 1'b1;
              r_nxt.st = pex_pkg::PEX_AACK;
            end else begin
              // another target's address: stay off the bus until the next START
              r_nxt.st = pex_pkg::PEX_IDLE;
            end
          end
        end
        pex_pkg::PEX_AACK, pex_pkg::PEX_WACK: begin
          if (scl_fall) begin
            r_nxt.cnt = 4'h0;
            if (r_r.st == pex_pkg::PEX_AACK && r_r.rw == pex_pkg::RW_READ) begin
              r_nxt.sh = pins_s;
              r_nxt.sda_oe = ~pins_s[7];
              r_nxt.st = pex_pkg::PEX_RDATA;
            end else begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = pex_pkg::PEX_WDATA;
            end
          end
        end
        pex_pkg::PEX_RDATA: begin
          if (scl_rise) begin
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r_r.cnt == pex_pkg::BIT_LAST) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = pex_pkg::PEX_RACK;
            end else begin
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.sda_oe = ~r_r.sh[6];
            end
          end
        end
        pex_pkg::PEX_RACK: begin
          if (scl_rise) begin
            r_nxt.nack = bus_s[pex_pkg::BUS_SDA];
          end else if (scl_fall) begin
            r_nxt.cnt = 4'h0;
            if (r_r.nack) begin
              r_nxt.st = pex_pkg::PEX_IDLE;
            end else begin
              r_nxt.sh = pins_s;
              r_nxt.sda_oe = ~pins_s[7];
              r_nxt.st = pex_pkg::PEX_RDATA;
            end
          end
        end
        default: begin
          r_nxt.st = pex_pkg::PEX_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    // the clear input drops any transfer; port latches and the alert keep their state
    if (!bus_s[pex_pkg::BUS_CLR]) begin
      r_nxt.st = pex_pkg::PEX_IDLE;
      r_nxt.cnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
      r_nxt.acc = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r_r <= '{st: pex_pkg::PEX_IDLE, scl_p: 1'b1, sda_p: 1'b1, outl: '1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = r_r.sda_oe;
  assign o_expander_pins_o = '0;
  assign o_expander_pins_oe = ~r_r.outl;
  assign o_pullup_en = r_r.pu_en;
  assign o_alert_n_o = 1'b0;
  assign o_alert_n_oe = r_r.alert;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence seq_watch_change;
    !clr_ev && (diff_m != '0);
  endsequence
  sequence seq_write_done;
    (r_r.st == pex_pkg::PEX_WDATA) && scl_fall && (r_r.cnt == pex_pkg::BIT_LAST) && !start_ev && !stop_ev
      && bus_s[pex_pkg::BUS_CLR];
  endsequence
  // an edge in the clear cycle legally keeps the alert on, so it is left out here
  sequence seq_stop_ours;
    stop_ev && r_r.acc && bus_s[pex_pkg::BUS_CLR] && (edge_m == '0);
  endsequence

  chk_alert_set: assert property (seq_watch_change |=> o_alert_n_oe)
    else $error("alert not raised after an input change");
  chk_alert_latched: assert property (o_alert_n_oe && !clr_ev |=> o_alert_n_oe)
    else $error("alert dropped without a bus access");
  chk_alert_clear: assert property (clr_ev && (edge_m == '0) |=> !o_alert_n_oe)
    else $error("alert not released after an access");
  chk_stop_release: assert property (seq_stop_ours ##1 (edge_m == '0) |=> !o_alert_n_oe)
    else $error("alert still low after STOP of an access");
  chk_ack_release: assert property (addr_hit && bus_s[pex_pkg::BUS_CLR] && (edge_m == '0)
    |=> o_sda_oe && !o_alert_n_oe)
    else $error("address acknowledge did not clear the alert");
  chk_snap_load: assert property (clr_ev |=> r_r.snap == $past(pins_s))
    else $error("snapshot not refreshed at clear");
  chk_port_write: assert property (seq_write_done |=> (o_expander_pins_oe == ~$past(r_r.sh)) && o_sda_oe)
    else $error("written byte did not reach the port pins");
  chk_clear_abort: assert property (!bus_s[pex_pkg::BUS_CLR] |=> (r_r.st == pex_pkg::PEX_IDLE) && !o_sda_oe)
    else $error("interface clear did not abandon the transfer");
  chk_addr_range: assert property (r_r.init_done |-> r_r.dev_addr[6:4] == pex_pkg::ADDR_BASE[6:4])
    else $error("target address outside 0x60 to 0x6F");
  chk_foreign_nack: assert property ((r_r.st == pex_pkg::PEX_ADDR) && scl_fall && (r_r.cnt == pex_pkg::BIT_LAST)
    && !addr_hit && !start_ev && !stop_ev |=> !o_sda_oe [*2])
    else $error("acknowledged a foreign address");
endmodule

/* File: tb/pex_host_model.sv */
// behavioural bus controller that drives the expander from the host side
`timescale 1ns/1ps
module pex_host_model (
  input wire logic i_ref_clk, // bench clock
  input wire logic i_sda, // resolved data line level
  output logic o_scl, // bus clock level, idles high
  output logic o_sda_low // pulls the data line low when high
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // a quarter of the bit period; the clock stands high outside frames
  task automatic qtr();
    repeat (2) @(posedge i_ref_clk);
  endtask
  // also serves as repeated start: data is released before the clock rises
  task automatic start_cond();
    o_sda_low <= 1'b0;
    qtr();
    o_scl <= 1'b1;
    qtr();
    o_sda_low <= 1'b1;
    qtr();
    o_scl <= 1'b0;
    qtr();
  endtask
  task automatic stop_cond();
    o_sda_low <= 1'b1;
    qtr();
    o_scl <= 1'b1;
    qtr();
    o_sda_low <= 1'b0;
    qtr();
    qtr();
  endtask
  // data changes only while the clock is low, so no false start or stop
  task automatic clk_bit(input logic b, output logic s);
    o_sda_low <= ~b;
    qtr();
    o_scl <= 1'b1;
    qtr();
    s = i_sda;
    qtr();
    o_scl <= 1'b0;
    qtr();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~ack, s);
  endtask
endmodule

/* File: tb/tb_i2c_open_drain_port_expander.sv */
// self-checking bench of the open-drain port expander
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("mismatch %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_i2c_open_drain_port_expander;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr_n = 1'b1;
  logic [1:0] sel_a = 2'h0;
  logic [1:0] sel_b = 2'h0;
  logic [7:0] ext_low = 8'h00;
  logic scl, sda_low, sda_oe, sda_o, alert_o, alert_oe, ack;
  logic [7:0] pins_o, pins_oe, rd;
  logic [1:0] pu;
  int err_total = 0;
  int check_count = 0;
  // pull-ups on the data line and on every port
  wire logic sda = ~(sda_low | sda_oe);
  wire logic [7:0] pins = ~(ext_low | pins_oe);
  pex_top dut (.i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_clr_n(clr_n), .i_addr_select_a(sel_a), .i_addr_select_b(sel_b), .i_expander_pins_i(pins),
    .o_expander_pins_o(pins_o), .o_expander_pins_oe(pins_oe), .o_pullup_en(pu), .o_alert_n_o(alert_o),
    .o_alert_n_oe(alert_oe));
  pex_host_model host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_alert(input logic v);
    int n;
    n = 0;
    while (alert_oe !== v && n < pex_pkg::PORT_MAX_CYC) begin
      @(posedge clk);
      n++;
    end
    `CHK("alert", v, alert_oe)
    if (alert_oe !== v) end_of_test();
  endtask
  task automatic do_reset(input logic [3:0] k);
    rst <= 1'b1;
    sel_a <= k[1:0];
    sel_b <= k[3:2];
    repeat (12) @(posedge clk);
    `CHK("rst", 12'h000, {sda_oe, pins_oe, pu, alert_oe})
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK("pwrup", {~{{4{k[2]}}, {4{k[0]}}}, k[3], k[1]}, {pins_oe, pu})
  endtask
  task automatic t_addr_map();
    for (int k = 0; k < 16; k++) begin
      do_reset(k[3:0]);
      host.start_cond();
      host.send_byte({3'h6, ~k[3], k[2:0], 1'b0}, ack);
      `CHK("nack", 1'b0, ack)
      host.start_cond();
      host.send_byte({3'h6, k[3:0], 1'b0}, ack);
      `CHK("ack", 1'b1, ack)
      host.stop_cond();
    end
  endtask
  // last mapping left all ports released at address 0x6F
  task automatic t_port_io();
    host.start_cond();
    host.send_byte(8'hDE, ack);
    host.send_byte(8'hA5, ack);
    host.stop_cond();
    `CHK("pins", 8'h5A, pins_oe)
    `CHK("drv", 10'h000, {pins_o, sda_o, alert_o})
    ext_low <= 8'h04;
    wait_alert(1'b1);
    ext_low <= 8'h00;
    repeat (20) @(posedge clk);
    `CHK("latched", 1'b1, alert_oe)
    ext_low <= 8'h04;
    host.start_cond();
    host.send_byte(8'hDF, ack);
    wait_alert(1'b0);
    // the host acknowledges the first byte, so a second byte follows
    host.recv_byte(1'b1, rd);
    `CHK("read", 8'hA1, rd)
    host.recv_byte(1'b0, rd);
    host.stop_cond();
    `CHK("read2", 8'hA1, rd)
    repeat (20) @(posedge clk);
    `CHK("quiet", 1'b0, alert_oe)
    host.start_cond();
    host.send_byte(8'hDE, ack);
    ext_low <= 8'h00;
    wait_alert(1'b1);
    host.send_byte(8'hA5, ack);
    host.stop_cond();
    wait_alert(1'b0);
  endtask
  // a byte cut short by the clear must not complete once clocking resumes
  task automatic t_clear();
    // port 6 reads low, so the expander is pulling the data line when the clear arrives
    host.start_cond();
    host.send_byte(8'hDF, ack);
    host.clk_bit(1'b1, ack);
    clr_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("clr_rd", 1'b0, sda_oe)
    clr_n <= 1'b1;
    repeat (5) @(posedge clk);
    host.stop_cond();
    host.start_cond();
    host.send_byte(8'hDE, ack);
    repeat (3) host.clk_bit(1'b0, ack);
    clr_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("clr_sda", 1'b0, sda_oe)
    clr_n <= 1'b1;
    repeat (5) @(posedge clk);
    host.send_byte(8'hFF, ack);
    host.stop_cond();
    `CHK("abandon", 9'h05A, {ack, pins_oe})
    host.start_cond();
    host.send_byte(8'hDE, ack);
    host.send_byte(8'hFF, ack);
    host.stop_cond();
    `CHK("again", 9'h100, {ack, pins_oe})
  endtask
  initial begin
    t_addr_map();
    t_port_io();
    t_clear();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
